// File: design/rot_lit_pkg.sv
// Shared constants, types and packed structs for the rotate and literal-return datapath
package rot_lit_pkg;

  localparam int unsigned DATA_W    = 8;
  localparam int unsigned ADDR_W    = 7;
  localparam int unsigned PC_W      = 15;
  localparam int unsigned MSB_BIT   = 7;
  localparam int unsigned LSB_BIT   = 0;
  localparam logic        DEST_ACC  = 1'h0;
  localparam logic        DEST_REG  = 1'h1;
  localparam logic [7:0]  ACC_RST   = 8'h00;
  localparam logic [7:0]  DATA_RST  = 8'h00;
  localparam logic [14:0] PC_RST    = 15'h0000;
  localparam logic [6:0]  ADDR_RST  = 7'h00;

  // Operation selector handed in by the decoder
  typedef enum logic [1:0] {
    OP_NONE  = 2'b00,
    OP_RETLIT = 2'b01,
    OP_ROTL  = 2'b10,
    OP_ROTR  = 2'b11
  } op_t;

  // Execution state of the core datapath
  typedef enum logic [0:0] {
    ST_IDLE   = 1'b0,
    ST_RET2   = 1'b1
  } state_t;

  // One issued instruction
  typedef struct packed {
    op_t              op;
    logic [DATA_W-1:0] literal;
    logic [ADDR_W-1:0] addr;
    logic             dest;
  } instr_t;

  // Write request towards data memory
  typedef struct packed {
    logic             we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } mem_wr_t;

endpackage

// File: design/rotate_through_carry.sv
// Combinational one-bit rotate through the carry flag
`timescale 1ns/10ps
module rotate_through_carry
  import rot_lit_pkg::*;
(
  input  wire logic              left,
  input  wire logic [DATA_W-1:0] din,
  input  wire logic              cin,
  output logic      [DATA_W-1:0] dout,
  output logic                   cout
);

  // Carry fills the vacated end, the expelled end becomes carry
  always_comb begin
    if (left) begin
      dout = {din[MSB_BIT-1:LSB_BIT], cin};
      cout = din[MSB_BIT];
    end else begin
      dout = {cin, din[MSB_BIT:LSB_BIT+1]};
      cout = din[LSB_BIT];
    end
  end

endmodule

// File: design/rotate_carry_and_literal_return.sv
// Execution datapath for return-with-literal and the two rotate-through-carry instructions
`timescale 1ns/10ps
module rotate_carry_and_literal_return
  import rot_lit_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              issue,
  input  wire instr_t            instr,
  input  wire logic [DATA_W-1:0] reg_rdata,
  input  wire logic [PC_W-1:0]   stack_top,
  output logic                   busy,
  output logic                   done,
  output logic [DATA_W-1:0]      acc,
  output logic                   carry,
  output mem_wr_t                mem_wr,
  output logic                   stack_pop,
  output logic                   pc_load,
  output logic [PC_W-1:0]        program_counter
);

  state_t            state_ff, nxt_state;
  logic [DATA_W-1:0] acc_ff, nxt_acc;
  logic              carry_ff, nxt_carry;
  mem_wr_t           wr_ff, nxt_wr;
  logic              pop_ff, nxt_pop;
  logic              pcl_ff, nxt_pcl;
  logic [PC_W-1:0]   pc_ff, nxt_pc;
  logic              done_ff, nxt_done;
  logic              busy_ff, nxt_busy;
  logic [DATA_W-1:0] rot_out;
  logic              rot_cout;
  logic              ret_take;
  logic              rot_take;

  // Both rotates share one decode, used by the rotate take flag that the checks rely on
  function automatic logic is_rotate(input op_t op);
    return (op == OP_ROTL) || (op == OP_ROTR);
  endfunction

  // An instruction is accepted only in idle; the return's refill slot drops issue
  assign ret_take = issue && (state_ff == ST_IDLE) && (instr.op == OP_RETLIT);
  assign rot_take = issue && (state_ff == ST_IDLE) && is_rotate(instr.op);

  // Shared rotator; direction follows the issued opcode
  // It reads the carry register, so back-to-back rotates chain through carry
  rotate_through_carry u_rot (
    .left (instr.op == OP_ROTL),
    .din  (reg_rdata),
    .cin  (carry_ff),
    .dout (rot_out),
    .cout (rot_cout)
  );

  // Next-state logic; new issues are ignored while the return's second cycle runs
  always_comb begin
    nxt_state = state_ff;
    nxt_acc   = acc_ff;
    nxt_carry = carry_ff;
    // Pulses default low; an idle write port shows zeros, not a stale address
    nxt_wr    = '{we: 1'h0, addr: ADDR_RST, data: DATA_RST};
    nxt_pop   = 1'h0;
    nxt_pcl   = 1'h0;
    nxt_pc    = pc_ff;
    nxt_done  = 1'h0;
    nxt_busy  = 1'h0;
    case (state_ff)
      ST_IDLE: begin
        if (issue) begin
          case (instr.op)
            OP_RETLIT: begin
              // Carry is left alone: the return changes no flag
              nxt_acc   = instr.literal;
              nxt_pop   = 1'h1;
              nxt_pc    = stack_top;
              nxt_pcl   = 1'h1;
              nxt_busy  = 1'h1;            // Second cycle follows
              nxt_state = ST_RET2;
            end
            OP_ROTL, OP_ROTR: begin
              nxt_carry = rot_cout;
              nxt_done  = 1'h1;            // Single cycle
              if (instr.dest == DEST_REG) begin
                nxt_wr = '{we: 1'h1, addr: instr.addr, data: rot_out};
              end else begin
                nxt_acc = rot_out;         // Register untouched
              end
            end
            default: begin
              nxt_state = ST_IDLE;
            end
          endcase
        end
      end
      ST_RET2: begin
        // Pipeline refill slot; the return retires here
        // Issue is not looked at, so a request in this slot is dropped
        nxt_done  = 1'h1;
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      acc_ff   <= ACC_RST;
      carry_ff <= 1'h0;
      wr_ff    <= '{we: 1'h0, addr: ADDR_RST, data: DATA_RST};
      pop_ff   <= 1'h0;
      pcl_ff   <= 1'h0;
      pc_ff    <= PC_RST;
      done_ff  <= 1'h0;
      busy_ff  <= 1'h0;
    end else begin
      state_ff <= nxt_state;
      acc_ff   <= nxt_acc;
      carry_ff <= nxt_carry;
      wr_ff    <= nxt_wr;
      pop_ff   <= nxt_pop;
      pcl_ff   <= nxt_pcl;
      pc_ff    <= nxt_pc;
      done_ff  <= nxt_done;
      busy_ff  <= nxt_busy;
    end
  end

  assign acc             = acc_ff;
  assign carry           = carry_ff;
  assign mem_wr          = wr_ff;
  assign stack_pop       = pop_ff;
  assign pc_load         = pcl_ff;
  assign program_counter = pc_ff;
  assign done            = done_ff;
  assign busy            = busy_ff;

  // Checks on the datapath; a take is qualified by the idle state, so the
  // refused refill slot of a return never arms a check that expects a result
  a_retlit_acc_load: assert property (@(posedge core_clk) disable iff (rst)
    ret_take |=> (acc == $past(instr.literal) && carry == $past(carry_ff)))
    else $error("literal not loaded or carry changed");

  // Carry must still hold its old value once the return has retired
  a_retlit_carry_hold: assert property (@(posedge core_clk) disable iff (rst)
    ret_take |=> ##1 (carry == $past(carry, 2)))
    else $error("carry moved during return");

  // Pop and load come first, retirement one cycle later
  a_retlit_two_cycle: assert property (@(posedge core_clk) disable iff (rst)
    ret_take
      |=> (stack_pop && pc_load && program_counter == $past(stack_top) && !done)
          ##1 (done && !stack_pop))
    else $error("return did not pop and retire in two cycles");

  a_retlit_busy_slot: assert property (@(posedge core_clk) disable iff (rst)
    ret_take |=> busy ##1 !busy)
    else $error("busy not raised for exactly the refill slot");

  // A request that lands in the refill slot must leave no trace at all
  a_ret2_refuses: assert property (@(posedge core_clk) disable iff (rst)
    (state_ff == ST_RET2)
      |=> (!stack_pop && !pc_load && !mem_wr.we &&
           acc == $past(acc) && carry == $past(carry)))
    else $error("issue taken during the return refill slot");

  // The program counter only moves together with its load strobe
  a_pc_hold_idle: assert property (@(posedge core_clk) disable iff (rst)
    !pc_load |-> (program_counter == $past(program_counter)))
    else $error("program counter moved without a load");

  // Result is checked wherever the destination bit sent it
  a_rotl_result: assert property (@(posedge core_clk) disable iff (rst)
    (rot_take && instr.op == OP_ROTL)
      |=> (carry == $past(reg_rdata[MSB_BIT]) &&
           (mem_wr.we ? mem_wr.data : acc) ==
             {$past(reg_rdata[MSB_BIT-1:LSB_BIT]), $past(carry_ff)}))
    else $error("rotate left result wrong");

  a_rotr_result: assert property (@(posedge core_clk) disable iff (rst)
    (rot_take && instr.op == OP_ROTR)
      |=> (carry == $past(reg_rdata[LSB_BIT]) &&
           (mem_wr.we ? mem_wr.data : acc) ==
             {$past(carry_ff), $past(reg_rdata[MSB_BIT:LSB_BIT+1])}))
    else $error("rotate right result wrong");

  // Rotates touch carry and one destination, never the stack or the counter
  a_rot_no_pop: assert property (@(posedge core_clk) disable iff (rst)
    rot_take |=> (!stack_pop && !pc_load && !busy &&
                  program_counter == $past(program_counter)))
    else $error("rotate disturbed the stack or program counter");

  // The write strobe follows the destination bit, with the issued address
  a_rot_dest_sel: assert property (@(posedge core_clk) disable iff (rst)
    rot_take |=> (mem_wr.we == $past(instr.dest) &&
                  (!mem_wr.we || mem_wr.addr == $past(instr.addr))))
    else $error("rotate destination select wrong");

  a_rot_acc_kept: assert property (@(posedge core_clk) disable iff (rst)
    (rot_take && instr.dest == DEST_REG) |=> (acc == $past(acc)))
    else $error("accumulator changed by a register rotate");

  // An idle write port shows zeros, so a stray address never leaks out
  a_wr_idle_clear: assert property (@(posedge core_clk) disable iff (rst)
    !mem_wr.we |-> (mem_wr.addr == ADDR_RST && mem_wr.data == DATA_RST))
    else $error("write port not cleared while idle");

  // The next cycle may carry a fresh rotate, so a second done is allowed only then
  a_rot_one_cycle: assert property (@(posedge core_clk) disable iff (rst)
    (rot_take && instr.dest == DEST_ACC)
      |=> (done && !busy && !mem_wr.we) ##1 (!done || $past(rot_take)))
    else $error("rotate not single cycle or register written");

endmodule

// File: test/rotate_carry_and_literal_return_tb_top.sv
// Self-checking testbench for the rotate and literal-return datapath
`timescale 1ns/10ps
module rotate_carry_and_literal_return_tb_top;
  import rot_lit_pkg::*;
  typedef struct packed {
    logic [7:0]  acc;
    logic        carry;
    mem_wr_t     wr;
    logic [15:0] pc;
    int          due;
  } exp_t;
  logic              core_clk  = 1'h0;
  logic              rst       = 1'h1;
  logic              issue     = 1'h0;
  instr_t            instr     = '0;
  logic [7:0]        reg_rdata = 8'h00;
  logic [PC_W-1:0]   stack_top = 15'h0000;
  logic              busy;
  logic              done;
  logic              carry;
  logic              stack_pop;
  logic              pc_load;
  logic [7:0]        acc;
  mem_wr_t           mem_wr;
  logic [PC_W-1:0]   program_counter;
  exp_t              exp_q[$];
  exp_t              m;
  logic [15:0]       m_pc      = 16'h0000;
  logic              popped    = 1'h0;
  logic              busy_d    = 1'h0;
  int                cyc       = 0;
  int                fails     = 0;
  int                compares  = 0;

  always #2 core_clk = ~core_clk;

  rotate_carry_and_literal_return dut (
    .core_clk(core_clk), .rst(rst), .issue(issue), .instr(instr), .reg_rdata(reg_rdata),
    .stack_top(stack_top), .busy(busy), .done(done), .acc(acc), .carry(carry),
    .mem_wr(mem_wr), .stack_pop(stack_pop), .pc_load(pc_load),
    .program_counter(program_counter));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic finish_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Drive one instruction and note its expected outcome; a return gets a refused rotate after it
  task automatic step(input op_t op, input logic d);
    logic [7:0] k;
    logic [7:0] r;
    logic [7:0] res;
    logic [6:0] a;
    logic [14:0] t;
    k = 8'($urandom);
    r = 8'($urandom);
    a = 7'($urandom);
    t = 15'($urandom);
    issue <= 1'h1;
    instr <= {op, k, a, d};
    reg_rdata <= r;
    stack_top <= t;
    res = (op == OP_ROTL) ? {r[6:0], m.carry} : {m.carry, r[7:1]};
    m.wr = '0;
    m.due = cyc + ((op == OP_RETLIT) ? 3 : 2);
    if (op == OP_RETLIT) begin
      m.acc = k;
      m.pc = {1'h1, t};
    end else if (op != OP_NONE) begin
      m.carry = (op == OP_ROTL) ? r[7] : r[0];
      m.pc[15] = 1'h0;
      if (d == DEST_ACC) m.acc = res;
      else m.wr = {1'h1, a, res};
    end
    if (op != OP_NONE) exp_q.push_back(m);
    @(posedge core_clk);
    if (op == OP_RETLIT) begin
      instr.op <= OP_ROTL;
      @(posedge core_clk);
    end
  endtask

  // Take the oldest note whenever an instruction retires
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    popped <= stack_pop & pc_load;
    busy_d <= busy;
    if (done === 1'h1) begin
      if (exp_q.size() == 0) begin
        chk("spare_done", 0, 1);
      end else begin
        m_pc = exp_q[0].pc;
        chk("acc", exp_q[0].acc, acc);
        chk("carry", exp_q[0].carry, carry);
        chk("mem_wr", exp_q[0].wr, mem_wr);
        chk("pc", m_pc, {popped, program_counter});
        chk("busy", {exp_q[0].pc[15], 1'h0}, {busy_d, busy});
        chk("pulses", 0, {stack_pop, pc_load});
        chk("latency", exp_q[0].due, cyc);
        void'(exp_q.pop_front());
      end
    end
  end

  // Watchdog sized well above 200 instructions of at most two cycles each
  initial begin
    repeat (3000) @(posedge core_clk);
    fails++;
    finish_test();
  end

  initial begin
    m = '0;
    void'($urandom(32'hADBA));
    repeat (20) @(posedge core_clk);
    rst <= 1'h0;
    chk("acc_rst", 0, acc);
    @(posedge core_clk);
    for (int i = 0; i < 200; i++) begin
      step(op_t'($urandom_range(3)), 1'($urandom));
    end
    issue <= 1'h0;
    repeat (4) @(posedge core_clk);
    chk("pending", 0, exp_q.size());
    finish_test();
  end
endmodule
